// ==== hdl/sera_slave.v ====
// Two-wire EEPROM slave: addressing, reads, staged page writes, protection and power states
// Operation
// - On matching read address, acknowledge then send byte at address counter.
// - Stop after word address only loads the counter; next read starts there.
// - After that stop, go standby and ignore bus until a start.
// - Each master acknowledge after a data byte makes the device send another.
// - Counter advances one per read byte across page boundaries.
// - Counter wraps from last address to zero and reading continues.
// - Direction bit one selects read, zero selects write.
// - Shift in full slave byte, compare, acknowledge only on match.
// - Word address comes from master or internal counter.
// - Power-up: standby, writes disabled, data pin released, reset output asserted.
// - Reject all writes unless write enable latch is set.
// - Start nonvolatile write only after full byte and acknowledge before stop.
// - Control register protection changes need a three-step sequence first.
// - Protect pin high with gate bit high blocks control register writes.
// - While reset output asserted, ignore bus and abort transfers.
// - Suppress writes to regions chosen by block protection bits.
// - Active on start; standby after mismatch, read stop, or write cycle.
// - Acknowledge address bytes and accepted data bytes; withhold it for a wrong slave byte or refused data.
// - Self-timed write lasts the write time after a valid stop.
`timescale 1ns/1ps
`include "sera_regs.vh"
module sera_slave #(
  parameter [3:0] DEV_TYPE_ID = `SERA_DEV_TYPE_ID,
  parameter [1:0] DEV_SEL = `SERA_DEV_SEL,
  parameter integer WC_CYC = `SERA_WC_CYC,
  parameter integer PURST_CYC = `SERA_PURST_CYC,
  parameter integer FIFO_DEPTH = `SERA_FIFO_DEPTH
) (
  input wire ref_clk,
  input wire rstn,
  input wire scl,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_n,
  input wire protect_pin,
  input wire write_enable_latch,
  input wire protect_pin_gate_bit,
  input wire ctrl_seq_armed,
  input wire [2:0] block_protect,
  output wire reset_out_n,
  output wire active,
  output wire nv_write_busy,
  output wire ctrl_reg_wr_ok
);
  localparam ST_IDLE = 6'h01;
  localparam ST_RX = 6'h02;
  localparam ST_RACK = 6'h04;
  localparam ST_TX = 6'h08;
  localparam ST_TACK = 6'h10;
  localparam ST_SKIP = 6'h20;
  localparam [1:0] K_SLV = 2'h0;
  localparam [1:0] K_AHI = 2'h1;
  localparam [1:0] K_ALO = 2'h2;
  localparam [1:0] K_DAT = 2'h3;
  localparam AW = `SERA_ADDR_W;
  localparam PW = `SERA_PAGE_W;
  localparam TW = `SERA_TMR_W;
  localparam integer STBY_N = `SERA_STBY_CYC;
  localparam [TW-1:0] STBY_T = STBY_N[TW-1:0];
  localparam [TW-1:0] WC_T = WC_CYC[TW-1:0];
  localparam [TW-1:0] POR_T = PURST_CYC[TW-1:0];

  function sera_prot;
    input [AW-1:0] a;
    input [2:0] bp;
    begin
      case (bp)
        `SERA_BP_1PG: sera_prot = (a[AW-1:6] == 5'h1f);
        `SERA_BP_2PG: sera_prot = (a[AW-1:7] == 4'hf);
        `SERA_BP_4PG: sera_prot = (a[AW-1:8] == 3'h7);
        `SERA_BP_8PG: sera_prot = (a[AW-1:9] == 2'h3);
        `SERA_BP_ALL: sera_prot = 1'b1;
        default: sera_prot = 1'b0;
      endcase
    end
  endfunction

  reg [7:0] mem_r [0:(1<<AW)-1];
  reg scl_q1, scl_q2, scl_d;
  reg sda_q1, sda_q2, sda_d;
  reg wp_q1, wp_q2;
  reg [5:0] st_r;
  reg [1:0] kind_r;
  reg [3:0] bit_r;
  reg [7:0] sh_r;
  reg [AW-1:0] addr_r;
  reg [2:0] ahi_r;
  reg rd_r, oe_n_r, act_r, more_r, ack_r, wrok_r, busy_r, sb_r;
  reg [TW-1:0] tmr_r, por_r;
  reg por_act_r, clr_r, push_r, cwok_r;
  reg [AW+7:0] pd_r;
  wire scl_rise, scl_fall, start_c, stop_c;
  wire slv_match, wr_ok;
  wire fifo_in_ready, fifo_out_valid;
  wire [AW+7:0] fifo_out_data;
  wire [7:0] rd_dat;

  assign scl_rise = scl_q2 & ~scl_d;
  assign scl_fall = ~scl_q2 & scl_d;
  assign start_c = scl_q2 & scl_d & sda_d & ~sda_q2;
  assign stop_c = scl_q2 & scl_d & ~sda_d & sda_q2;
  assign slv_match = (sh_r[`SERA_ID_MSB:`SERA_ID_LSB] == DEV_TYPE_ID) &&
    (sh_r[`SERA_ZERO_POS] == `SERA_FIXED_ZERO) && (sh_r[`SERA_SEL_MSB:`SERA_SEL_LSB] == DEV_SEL);
  assign wr_ok = write_enable_latch & fifo_in_ready & ~sera_prot(addr_r, block_protect);
  assign rd_dat = mem_r[addr_r];
  assign sda_o = 1'b0;
  assign sda_oe_n = oe_n_r;
  assign reset_out_n = ~por_act_r;
  assign active = act_r;
  assign nv_write_busy = busy_r;
  assign ctrl_reg_wr_ok = cwok_r;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_q1 <= 1'b1;
      scl_q2 <= 1'b1;
      scl_d <= 1'b1;
      sda_q1 <= 1'b1;
      sda_q2 <= 1'b1;
      sda_d <= 1'b1;
      wp_q1 <= 1'b0;
      wp_q2 <= 1'b0;
      cwok_r <= 1'b0;
    end else begin
      scl_q1 <= scl;
      scl_q2 <= scl_q1;
      scl_d <= scl_q2;
      sda_q1 <= sda_i;
      sda_q2 <= sda_q1;
      sda_d <= sda_q2;
      wp_q1 <= protect_pin;
      wp_q2 <= wp_q1;
      // Control register writes need the latch, the armed sequence and no pin lock
      cwok_r <= ~por_act_r & write_enable_latch & ctrl_seq_armed & ~(wp_q2 & protect_pin_gate_bit);
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      por_r <= POR_T;
      por_act_r <= 1'b1;
    end else if (por_act_r) begin
      if (por_r <= 1)
        por_act_r <= 1'b0;
      else
        por_r <= por_r - 1'b1;
    end
  end

  // Array update happens only while draining staged bytes in the write cycle
  always @(posedge ref_clk) begin
    if (busy_r && fifo_out_valid)
      mem_r[fifo_out_data[AW+7:8]] <= fifo_out_data[7:0];
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_IDLE;
      kind_r <= K_SLV;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      rd_r <= 1'b0;
      addr_r <= {AW{1'b0}};
      ahi_r <= 3'h0;
      oe_n_r <= 1'b1;
      act_r <= 1'b0;
      more_r <= 1'b0;
      ack_r <= 1'b0;
      wrok_r <= 1'b0;
      busy_r <= 1'b0;
      sb_r <= 1'b0;
      tmr_r <= {TW{1'b0}};
      clr_r <= 1'b0;
      push_r <= 1'b0;
      pd_r <= {(AW+8){1'b0}};
    end else begin
      clr_r <= 1'b0;
      push_r <= 1'b0;
      if (por_act_r) begin
        st_r <= ST_IDLE;
        oe_n_r <= 1'b1;
        act_r <= 1'b0;
        wrok_r <= 1'b0;
        clr_r <= 1'b1;
      end else if (busy_r) begin
        // Inputs are deaf during the write cycle, so polling sees no acknowledge
        if (tmr_r != {TW{1'b0}})
          tmr_r <= tmr_r - 1'b1;
        else if (!fifo_out_valid) begin
          busy_r <= 1'b0;
          act_r <= 1'b0;
        end
      end else if (start_c) begin
        st_r <= ST_RX;
        kind_r <= K_SLV;
        bit_r <= 4'h0;
        rd_r <= 1'b0;
        oe_n_r <= 1'b1;
        act_r <= 1'b1;
        sb_r <= 1'b0;
        wrok_r <= 1'b0;
        clr_r <= 1'b1;
      end else if (stop_c) begin
        st_r <= ST_IDLE;
        oe_n_r <= 1'b1;
        wrok_r <= 1'b0;
        if (wrok_r && fifo_out_valid && st_r == ST_RX && bit_r == 4'h1) begin // Stop's own SCL rise counts one bit
          busy_r <= 1'b1;
          tmr_r <= WC_T;
        end else begin
          clr_r <= 1'b1;
          sb_r <= 1'b1;
          tmr_r <= STBY_T;
        end
      end else begin
        if (sb_r) begin
          if (tmr_r <= 1) begin
            sb_r <= 1'b0;
            act_r <= 1'b0;
          end else
            tmr_r <= tmr_r - 1'b1;
        end
        case (st_r)
          ST_RX: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_q2};
              bit_r <= bit_r + 1'b1;
            end else if (scl_fall && bit_r == 4'h8) begin
              st_r <= ST_RACK;
              case (kind_r)
                K_SLV: begin
                  if (slv_match) begin
                    rd_r <= sh_r[`SERA_RW_POS];
                    ack_r <= 1'b1;
                    oe_n_r <= 1'b0;
                  end else
                    st_r <= ST_SKIP;
                end
                K_AHI: begin
                  ahi_r <= sh_r[`SERA_AHI_W-1:0];
                  kind_r <= K_ALO;
                  ack_r <= 1'b1;
                  oe_n_r <= 1'b0;
                end
                K_ALO: begin
                  addr_r <= {ahi_r, sh_r};
                  kind_r <= K_DAT;
                  ack_r <= 1'b1;
                  oe_n_r <= 1'b0;
                end
                default: begin
                  // Refused data withholds the acknowledge and is not staged: clear latch, protected address or full stage
                  ack_r <= wr_ok;
                  oe_n_r <= ~wr_ok;
                  if (wr_ok) begin
                    push_r <= 1'b1;
                    pd_r <= {addr_r, sh_r};
                    addr_r <= {addr_r[AW-1:PW], addr_r[PW-1:0] + 1'b1};
                  end
                end
              endcase
            end
          end
          ST_RACK: begin
            if (scl_fall) begin
              oe_n_r <= 1'b1;
              bit_r <= 4'h0;
              if (kind_r == K_SLV && rd_r) begin
                sh_r <= rd_dat;
                oe_n_r <= rd_dat[7];
                st_r <= ST_TX;
              end else begin
                st_r <= ST_RX;
                if (kind_r == K_SLV)
                  kind_r <= K_AHI;
                if (kind_r == K_DAT && ack_r)
                  wrok_r <= 1'b1;
              end
            end
          end
          ST_TX: begin
            if (scl_rise)
              bit_r <= bit_r + 1'b1;
            else if (scl_fall) begin
              if (bit_r == 4'h8) begin
                oe_n_r <= 1'b1;
                addr_r <= addr_r + 1'b1;
                more_r <= 1'b0;
                st_r <= ST_TACK;
              end else begin
                oe_n_r <= sh_r[6];
                sh_r <= {sh_r[6:0], 1'b0};
              end
            end
          end
          ST_TACK: begin
            if (scl_rise)
              more_r <= ~sda_q2;
            else if (scl_fall) begin
              bit_r <= 4'h0;
              if (more_r) begin
                sh_r <= rd_dat;
                oe_n_r <= rd_dat[7];
                st_r <= ST_TX;
              end else
                st_r <= ST_IDLE;
            end
          end
          ST_SKIP: begin
            if (scl_rise) begin
              st_r <= ST_IDLE;
              act_r <= 1'b0;
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  sera_fifo #(.W(AW + 8), .D(FIFO_DEPTH), .AW(`SERA_FIFO_AW)) u_stage (
    .clk(ref_clk),
    .rstn(rstn),
    .clr(clr_r),
    .in_valid(push_r),
    .in_ready(fifo_in_ready),
    .in_data(pd_r),
    .out_valid(fifo_out_valid),
    .out_ready(busy_r),
    .out_data(fifo_out_data)
  );
endmodule // sera_slave

// ==== hdl/sera_regs.vh ====
// Constants for the two-wire serial EEPROM slave: timing, address layout, protection codes
`ifndef SERA_REGS_VH
`define SERA_REGS_VH

`define SERA_CLK_MHZ 25
`define SERA_STBY_NS 200
`define SERA_STBY_CYC ((`SERA_STBY_NS * `SERA_CLK_MHZ) / 1000)
`define SERA_WC_MS 10
`define SERA_WC_CYC (`SERA_WC_MS * `SERA_CLK_MHZ * 1000)
`define SERA_PURST_MS 250
`define SERA_PURST_CYC (`SERA_PURST_MS * `SERA_CLK_MHZ * 1000)
`define SERA_TMR_W 24

// Arbitrary device type code, not tied to any part
`define SERA_DEV_TYPE_ID 4'h5
`define SERA_DEV_SEL 2'h0
`define SERA_FIXED_ZERO 1'b0
`define SERA_ID_MSB 7
`define SERA_ID_LSB 4
`define SERA_ZERO_POS 3
`define SERA_SEL_MSB 2
`define SERA_SEL_LSB 1
`define SERA_RW_POS 0

`define SERA_ADDR_W 11
`define SERA_PAGE_W 6
`define SERA_AHI_W 3
`define SERA_FIFO_DEPTH 16
`define SERA_FIFO_AW 4

`define SERA_BP_NONE 3'h0
`define SERA_BP_1PG 3'h1
`define SERA_BP_2PG 3'h2
`define SERA_BP_4PG 3'h3
`define SERA_BP_8PG 3'h4
`define SERA_BP_ALL 3'h5

`endif

// ==== hdl/sera_fifo.v ====
// Synchronous FIFO with valid/ready on both sides and a clear input
`timescale 1ns/1ps
module sera_fifo #(
  parameter W = 19,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rstn,
  input wire clr,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_r [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;

  assign in_ready = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (clr) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wp_r <= (wp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      if (pop)
        rp_r <= (rp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      if (push && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule // sera_fifo

// ==== test/sera_slave_assertions.sv ====
// Port checker for the two-wire EEPROM slave, bound to its top module
`timescale 1ns/1ps
module sera_chk #(
  parameter integer WC_CYC = 250000
) (
  input wire ref_clk,
  input wire rstn,
  input wire scl,
  input wire sda_i,
  input wire sda_oe_n,
  input wire protect_pin,
  input wire write_enable_latch,
  input wire protect_pin_gate_bit,
  input wire ctrl_seq_armed,
  input wire reset_out_n,
  input wire active,
  input wire nv_write_busy,
  input wire ctrl_reg_wr_ok
);
  reg [31:0] busy_len_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      busy_len_r <= 32'h0;
    else if (nv_write_busy)
      busy_len_r <= busy_len_r + 32'h1;
    else
      busy_len_r <= 32'h0;
  end
  chk_por_quiet: assert property (!reset_out_n |-> sda_oe_n && !active)
    else $error("bus answered during reset output");
  chk_por_nowrite: assert property (!reset_out_n |-> !nv_write_busy && !ctrl_reg_wr_ok)
    else $error("write possible during reset output");
  chk_gate_block: assert property ((protect_pin && protect_pin_gate_bit)[*5] |=> !ctrl_reg_wr_ok)
    else $error("control write allowed while gated");
  chk_wel_ctrl: assert property ((!write_enable_latch)[*2] |=> !ctrl_reg_wr_ok)
    else $error("control write allowed without latch");
  chk_ctrl_grant: assert property ((reset_out_n && write_enable_latch && ctrl_seq_armed
    && !protect_pin_gate_bit)[*3] |=> ctrl_reg_wr_ok)
    else $error("control write refused when allowed");
  chk_busy_wel: assert property ($rose(nv_write_busy) |-> write_enable_latch)
    else $error("write cycle without latch");
  chk_busy_quiet: assert property (nv_write_busy |-> sda_oe_n)
    else $error("data driven during write cycle");
  chk_busy_len: assert property (busy_len_r <= WC_CYC + 16)
    else $error("write cycle too long");
  chk_stop_stby: assert property (scl && $rose(sda_i) && !nv_write_busy
    |-> ##[1:12] (!active || nv_write_busy))
    else $error("no standby after stop");
  chk_start_wake: assert property (scl && $fell(sda_i) && reset_out_n && !nv_write_busy
    |-> ##[1:8] active)
    else $error("start did not wake device");
  chk_sda_edge: assert property ($changed(sda_oe_n) |-> !$past(scl, 2))
    else $error("data changed while clock high");
endmodule // sera_chk
bind sera_slave sera_chk #(.WC_CYC(WC_CYC)) i_sera_chk (.ref_clk(ref_clk), .rstn(rstn), .scl(scl), .sda_i(sda_i),
  .sda_oe_n(sda_oe_n), .protect_pin(protect_pin), .write_enable_latch(write_enable_latch),
  .protect_pin_gate_bit(protect_pin_gate_bit), .ctrl_seq_armed(ctrl_seq_armed), .reset_out_n(reset_out_n),
  .active(active), .nv_write_busy(nv_write_busy), .ctrl_reg_wr_ok(ctrl_reg_wr_ok));

// ==== test/sera_mst.sv ====
// Bus master model: drives SCL and an open-drain SDA, reads the wire back
`timescale 1ns/1ps
module sera_mst (
  output reg scl,
  output reg sda_rel,
  input wire sda_wire
);
  localparam integer Q = 80;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // Odd offset keeps SCL edges away from the system clock edges
  task automatic bus_start();
    #7;
    sda_rel <= 1'b1;
    #(2*Q) scl <= 1'b1;
    #Q sda_rel <= 1'b0;
    #Q scl <= 1'b0;
    #Q;
  endtask
  task automatic bus_stop();
    sda_rel <= 1'b0;
    #Q scl <= 1'b1;
    #Q sda_rel <= 1'b1;
    #(2*Q);
  endtask
  task automatic wbit(input logic b);
    sda_rel <= b;
    #Q scl <= 1'b1;
    #(2*Q) scl <= 1'b0;
    #Q;
  endtask
  task automatic rbit(output logic b);
    sda_rel <= 1'b1;
    #Q scl <= 1'b1;
    #Q b = sda_wire;
    #Q scl <= 1'b0;
    #Q;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) wbit(d[i]);
    rbit(b);
    ack = !b;
  endtask
  task automatic rbyte(output logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    wbit(!ack);
  endtask
endmodule // sera_mst

// ==== test/tb_top.sv ====
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/1ps
`include "sera_regs.vh"
module tb_top;
  localparam [7:0] SLV_W = {`SERA_DEV_TYPE_ID, 1'b0, `SERA_DEV_SEL, 1'b0};
  localparam [7:0] SLV_R = SLV_W | 8'h01;
  reg ref_clk = 1'b0;
  reg rstn = 1'b0;
  reg protect_pin = 1'b0;
  reg write_enable_latch = 1'b0;
  reg protect_pin_gate_bit = 1'b0;
  reg ctrl_seq_armed = 1'b0;
  reg [2:0] block_protect = 3'h0;
  wire scl, sda_rel, sda_wire, sda_o, sda_oe_n, reset_out_n, active, nv_write_busy, ctrl_reg_wr_ok;
  integer fails = 0;
  integer num_checks = 0;
  integer cycles = 0;
  logic ack;
  logic [7:0] rd;
  assign sda_wire = sda_rel & (sda_oe_n | sda_o);
  always #20 ref_clk = ~ref_clk;
  sera_slave #(.WC_CYC(200), .PURST_CYC(100)) i_sera_slave (.ref_clk(ref_clk), .rstn(rstn), .scl(scl),
    .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .protect_pin(protect_pin),
    .write_enable_latch(write_enable_latch), .protect_pin_gate_bit(protect_pin_gate_bit),
    .ctrl_seq_armed(ctrl_seq_armed), .block_protect(block_protect), .reset_out_n(reset_out_n),
    .active(active), .nv_write_busy(nv_write_busy), .ctrl_reg_wr_ok(ctrl_reg_wr_ok));
  sera_mst i_sera_mst (.scl(scl), .sda_rel(sda_rel), .sda_wire(sda_wire));
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails = fails + 1;
      conclude();
    end
  end
  task automatic chk1(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      $display("wrong value %s exp %b got %b", nm, e, g);
      fails++;
    end
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      $display("wrong value %s exp %h got %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic wb(input logic [7:0] d, input logic e);
    i_sera_mst.wbyte(d, ack);
    chk1("ack", e, ack);
  endtask
  task automatic rb(input logic [7:0] e, input logic k);
    i_sera_mst.rbyte(rd, k);
    chk8("data", e, rd);
  endtask
  task automatic set_addr(input logic [10:0] a);
    i_sera_mst.bus_start();
    wb(SLV_W, 1'b1);
    wb({5'h00, a[10:8]}, 1'b1);
    wb(a[7:0], 1'b1);
  endtask
  // Bounded wait for standby, long enough for a full write cycle
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    repeat (1000) if (active || nv_write_busy) @(posedge ref_clk);
    chk1("active", 1'b0, active);
    @(posedge ref_clk);
  endtask
  task automatic t_power_up();
    chk1("reset_out_n", 1'b0, reset_out_n);
    chk1("sda_oe_n", 1'b1, sda_oe_n);
    chk1("sda_o", 1'b0, sda_o);
    i_sera_mst.bus_start();
    wb(SLV_W, 1'b0);
    i_sera_mst.bus_stop();
    repeat (200) if (!reset_out_n) @(posedge ref_clk);
    chk1("reset_out_n", 1'b1, reset_out_n);
    @(posedge ref_clk);
  endtask
  task automatic t_write(input logic [10:0] a, input logic [7:0] d0, input integer n);
    set_addr(a);
    for (int i = 0; i < n; i++) wb(d0 + i[7:0], 1'b1);
    i_sera_mst.bus_stop();
    repeat (8) @(posedge ref_clk);
    chk1("busy", 1'b1, nv_write_busy);
    settle();
  endtask
  task automatic t_partial();
    set_addr(11'h000);
    repeat (4) i_sera_mst.wbit(1'b0);
    i_sera_mst.bus_stop();
    repeat (8) @(posedge ref_clk);
    chk1("busy", 1'b0, nv_write_busy);
    settle();
  endtask
  task automatic t_random_read();
    set_addr(11'h7fe);
    i_sera_mst.bus_start();
    wb(SLV_R, 1'b1);
    rb(8'ha0, 1'b1);
    rb(8'ha1, 1'b1);
    rb(8'hb0, 1'b0);
    i_sera_mst.bus_stop();
    settle();
  endtask
  task automatic t_set_current();
    set_addr(11'h7ff);
    i_sera_mst.bus_stop();
    settle();
    chk1("busy", 1'b0, nv_write_busy);
    i_sera_mst.bus_start();
    wb(SLV_R, 1'b1);
    rb(8'ha1, 1'b1);
    rb(8'hb0, 1'b0);
    i_sera_mst.bus_stop();
    settle();
  endtask
  task automatic t_protect();
    logic e;
    for (int k = 0; k < 9; k++) begin
      block_protect <= k[2:0];
      write_enable_latch <= (k < 8);
      e = (k == 0 || k == 6 || k == 7);
      @(posedge ref_clk);
      set_addr(11'h7ff);
      wb(8'ha1, e);
      i_sera_mst.bus_stop();
      repeat (8) @(posedge ref_clk);
      chk1("busy", e, nv_write_busy);
      settle();
    end
    block_protect <= 3'h0;
    write_enable_latch <= 1'b1;
  endtask
  task automatic t_mismatch();
    for (int k = 0; k < 3; k++) begin
      i_sera_mst.bus_start();
      wb(SLV_W ^ (8'h02 << (k * 2)), 1'b0);
      repeat (4) @(posedge ref_clk);
      chk1("active", 1'b0, active);
      i_sera_mst.bus_stop();
      settle();
    end
  endtask
  task automatic t_ctrl();
    for (int k = 0; k < 16; k++) begin
      {protect_pin, protect_pin_gate_bit, write_enable_latch, ctrl_seq_armed} <= k[3:0];
      repeat (6) @(posedge ref_clk);
      chk1("ctrl_ok", k[1:0] == 2'h3 && k[3:2] != 2'h3, ctrl_reg_wr_ok);
    end
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_power_up();
    write_enable_latch <= 1'b1;
    t_write(11'h7fe, 8'ha0, 2);
    t_write(11'h000, 8'hb0, 1);
    t_partial();
    t_random_read();
    t_set_current();
    t_protect();
    t_mismatch();
    t_ctrl();
    conclude();
  end
endmodule // tb_top
